// ===== dv/tb.sv
// self-checking bench for the level select bank against a reference model
`timescale 1ns/1ps
module tb import ils_pkg::*; ();

// ----------------------------------------------------------------------
// signals and model state
// ----------------------------------------------------------------------
logic mclk;
logic nrst;
logic wr;
logic rd;
logic word;
logic level_ctrl_on;
logic [15:0] addr;
logic [15:0] wdata;
logic [15:0] rdata_q;
logic [23:0] irq_pend;
logic [47:0] lvl_all;
logic [47:0] lvl_small;
logic grant_vld;
logic [4:0] grant_id;
ils_lvl_t grant_lvl;
int n_errors;
int compares;
// model registers a, b, c and c of the small variant
int m[4];
int wmask[4] = '{32'h0000FFF3, 32'h0000FF3F, 32'h0000FFFF, 32'h0000FFF0};

initial mclk = 1'b0;
always #5 mclk = ~mclk;

// ----------------------------------------------------------------------
// devices: full pin count and a small variant without serial 20/21
// ----------------------------------------------------------------------
ils_top #(.PIN_COUNT(100)) u_dut (.mclk(mclk), .nrst(nrst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .word(word), .rdata_q(rdata_q),
	.level_ctrl_on(level_ctrl_on), .irq_pend(irq_pend), .lvl_all(lvl_all),
	.grant_vld(grant_vld), .grant_id(grant_id), .grant_lvl(grant_lvl));

ils_top #(.PIN_COUNT(64)) u_dut_small (.mclk(mclk), .nrst(nrst),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .word(word),
	.rdata_q(), .level_ctrl_on(level_ctrl_on), .irq_pend(irq_pend),
	.lvl_all(lvl_small), .grant_vld(), .grant_id(), .grant_lvl());

// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
function automatic int reg_of(logic [15:0] a, logic wo);
	if (a < 16'hF03A || a > 16'hF03F || (wo && a[0])) return -1;
	return int'((a - 16'hF03A) >> 1);
endfunction

function automatic int upd(int old, int msk);
	if (word) return wdata & msk;
	if (addr[0]) return (old & 32'h00FF) | ((wdata[7:0] << 8) & msk);
	return (old & 32'hFF00) | (wdata[7:0] & msk);
endfunction

task chk(input logic [47:0] seen, input logic [47:0] exp);
	compares++;
	if (seen !== exp) begin
		n_errors++;
		$display("BAD %0t seen %h expected %h", $time, seen, exp);
	end
endtask

task acc(input int op, input logic [15:0] a, input logic [15:0] d,
	input logic wo, input logic on);
	@(posedge mclk);
	wr <= (op == 1);
	rd <= (op == 2);
	addr <= a;
	wdata <= d;
	word <= wo;
	level_ctrl_on <= on;
endtask

task stop_test;
	$display("errors %0d compares %0d", n_errors, compares);
	if (n_errors == 0 && compares > 0) begin
		$display("Regression OK");
	end else begin
		$display("Regression broken");
	end
	$finish;
endtask

// ----------------------------------------------------------------------
// model: predict each edge from the values sampled at it
// ----------------------------------------------------------------------
always @(posedge mclk) begin
	int r;
	int bl;
	int bid;
	int lv;
	int e_rd;
	if (nrst) begin
		r = reg_of(addr, word);
		bl = -1;
		bid = 0;
		e_rd = 0;
		// highest level wins, lower slot on a tie; reserved slots excluded
		for (int i = 0; i < 24; i++) begin
			lv = level_ctrl_on ? (m[i / 8] >> (i % 8 * 2)) & 3 : 0;
			if (irq_pend[i] && i != 1 && i != 11 && lv > bl) begin
				bl = lv;
				bid = i;
			end
		end
		if (rd && r >= 0) e_rd = word ? m[r] : (addr[0] ? m[r] >> 8 : m[r] & 32'h00FF);
		if (wr && level_ctrl_on && r >= 0) begin
			m[r] = upd(m[r], wmask[r]);
			if (r == 2) m[3] = upd(m[3], wmask[3]);
		end
		#1;
		chk(lvl_all, {m[2][15:0], m[1][15:0], m[0][15:0]});
		chk(lvl_small[47:32], m[3][15:0]);
		chk(rdata_q, e_rd[15:0]);
		chk(grant_vld, bl >= 0);
		if (bl >= 0) chk({grant_id, grant_lvl}, {bid[4:0], bl[1:0]});
	end
end

// ----------------------------------------------------------------------
// stimulus
// ----------------------------------------------------------------------
initial begin
	nrst = 1'b0;
	wr = 1'b0;
	rd = 1'b0;
	word = 1'b0;
	addr = 16'h0000;
	wdata = 16'h0000;
	level_ctrl_on = 1'b0;
	irq_pend = 24'h000000;
	n_errors = 0;
	compares = 0;
	m = '{0, 0, 0, 0};
	void'($urandom(32'h6BCF00E1));
	repeat (2) @(posedge mclk);
	nrst <= 1'b1;
	// reset values, then writes with control on and off
	acc(2, 16'hF03A, 16'h0000, 1'b1, 1'b0);
	acc(2, 16'hF03C, 16'h0000, 1'b1, 1'b0);
	acc(2, 16'hF03E, 16'h0000, 1'b1, 1'b0);
	acc(1, 16'hF03A, 16'hFFFF, 1'b1, 1'b1);
	acc(2, 16'hF03B, 16'h0000, 1'b0, 1'b1);
	acc(1, 16'hF03C, 16'hFFFF, 1'b1, 1'b0);
	acc(1, 16'hF03E, 16'hFFFF, 1'b1, 1'b1);
	acc(2, 16'hF03C, 16'h0000, 1'b1, 1'b1);
	// irq_pend stands for enabled requests only; enables live outside
	repeat (3000) begin
		acc($urandom % 3, 16'hF038 + 16'($urandom % 10), 16'($urandom),
			1'($urandom % 2), ($urandom % 4) != 0);
		// reserved slots pend too, so their exclusion is exercised
		irq_pend <= 24'($urandom & $urandom);
	end
	acc(0, 16'h0000, 16'h0000, 1'b0, 1'b1);
	irq_pend <= 24'h000000;
	repeat (2) @(posedge mclk);
	stop_test;
end

initial begin
	#100000;
	n_errors++;
	stop_test;
end

endmodule // tb

// ===== hw/ils_arb.sv
// level then fixed priority selection among pending sources
`timescale 1ns/1ps
`include "ils_regs.svh"
module ils_arb import ils_pkg::*; #(
	parameter int N = 24,
	parameter int IW = 5
) (
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [N-1:0] pend, // pending sources
	input wire logic [2*N-1:0] lvls, // level field per source
	input wire logic lvl_en, // level control switched on
	output logic grant_vld_q, // a source is selected
	output logic [IW-1:0] grant_id_q, // selected source index
	output ils_lvl_t grant_lvl_q // level of the selected source
);

	logic best_v;
	logic [IW-1:0] best_i;
	ils_lvl_t best_l;

	// ------------------------------------------------------------------
	// search: higher code wins, lower index wins a tie
	// ------------------------------------------------------------------
	always_comb begin
		ils_lvl_t l;
		l = `ILS_LVL1;
		best_v = 1'b0;
		best_i = '0;
		best_l = `ILS_LVL1;
		for (int i = N - 1; i >= 0; i--) begin
			l = lvl_en ? lvls[2*i +: 2] : `ILS_LVL1;
			if (pend[i] && (!best_v || l >= best_l)) begin
				best_v = 1'b1;
				best_i = IW'(i);
				best_l = l;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			grant_vld_q <= 1'b0;
			grant_id_q <= '0;
			grant_lvl_q <= `ILS_LVL1;
		end else begin
			grant_vld_q <= best_v;
			grant_id_q <= best_i;
			grant_lvl_q <= best_l;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	logic [N-1:0] pend_h_q;
	logic [2*N-1:0] lvls_h_q;
	logic en_h_q;
	logic beat;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pend_h_q <= '0;
			lvls_h_q <= '0;
			en_h_q <= 1'b0;
		end else begin
			pend_h_q <= pend;
			lvls_h_q <= lvls;
			en_h_q <= lvl_en;
		end
	end

	// a pending source that should have won over the grant
	always_comb begin
		ils_lvl_t lj;
		lj = `ILS_LVL1;
		beat = 1'b0;
		for (int j = 0; j < N; j++) begin
			lj = en_h_q ? lvls_h_q[2*j +: 2] : `ILS_LVL1;
			if (pend_h_q[j] && (lj > grant_lvl_q ||
				(lj == grant_lvl_q && IW'(j) < grant_id_q)))
				beat = 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_grant_best_source: assert property (
		grant_vld_q |-> !beat)
		else $error("a better pending source was passed over");
	a_grant_level_field: assert property (
		grant_vld_q && en_h_q |->
		grant_lvl_q == lvls_h_q[2*grant_id_q +: 2])
		else $error("granted level differs from its field");
	a_grant_needs_pend: assert property (
		grant_vld_q == $past(|pend))
		else $error("grant valid does not follow pending");
	c_grant_top_level: cover property (grant_vld_q &&
		grant_lvl_q == `ILS_LVL4);

endmodule // ils_arb

// ===== hw/ils_pkg.sv
// types shared by the level select bank
package ils_pkg;
	typedef logic [1:0] ils_lvl_t;
	typedef enum logic [1:0] {ILS_SEL_NONE, ILS_SEL_A, ILS_SEL_B,
		ILS_SEL_C} ils_sel_t;
	typedef enum logic [1:0] {ILS_LANE_LO, ILS_LANE_HI,
		ILS_LANE_WORD} ils_lane_t;
	typedef struct packed {
		ils_sel_t sel;
		ils_lane_t lane;
	} ils_dec_t;
endpackage

// ===== hw/ils_regs.svh
// offsets, field positions, masks and reset values of the level select bank
`ifndef ILS_REGS_SVH
`define ILS_REGS_SVH

// ----------------------------------------------------------------------
// addresses
// ----------------------------------------------------------------------
`define ILS_ADDR_A 16'hF03A
`define ILS_ADDR_B 16'hF03C
`define ILS_ADDR_C 16'hF03E

// ----------------------------------------------------------------------
// reset value, level codes, masks
// ----------------------------------------------------------------------
`define ILS_RESET 16'h0000
`define ILS_LVL1 2'h0
`define ILS_LVL4 2'h3
`define ILS_RSV_A 16'h000C
`define ILS_RSV_B 16'h00C0
`define ILS_SER2X_C 16'h000F
`define ILS_SER2X_MIN_PINS 80

// ----------------------------------------------------------------------
// field low bit positions
// ----------------------------------------------------------------------
`define ILS_A_TIMER1 14
`define ILS_A_TIMER0 12
`define ILS_A_FUNCTIMER1 10
`define ILS_A_FUNCTIMER0 8
`define ILS_A_TWOWIRE_MASTER1 6
`define ILS_A_TWOWIRE_MASTER0 4
`define ILS_A_EXPANDED_EXT 0
`define ILS_B_TIMER3 14
`define ILS_B_TIMER2 12
`define ILS_B_FUNCTIMER3 10
`define ILS_B_FUNCTIMER2 8
`define ILS_B_SERIAL11 4
`define ILS_B_SERIAL10 2
`define ILS_B_TWOWIRE_UNIT0 0
`define ILS_C_TIMER5 14
`define ILS_C_TIMER4 12
`define ILS_C_FUNCTIMER5 10
`define ILS_C_FUNCTIMER4 8
`define ILS_C_COMPARATOR1 6
`define ILS_C_COMPARATOR0 4
`define ILS_C_SERIAL21 2
`define ILS_C_SERIAL20 0

`endif

// ===== hw/ils_top.sv
// three interrupt level select registers with their level arbiter
`timescale 1ns/1ps
`include "ils_regs.svh"
module ils_top import ils_pkg::*; #(
	parameter int PIN_COUNT = 100
) (
	input wire logic mclk, // system clock, 100 MHz
	input wire logic nrst, // async reset, active low
	input wire logic [15:0] addr, // byte address
	input wire logic [15:0] wdata, // write data, bytes in [7:0]
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic word, // 1 word access, 0 byte access
	output logic [15:0] rdata_q, // read data, cycle after rd
	input wire logic level_ctrl_on, // level control enable bit
	input wire logic [23:0] irq_pend, // pending source per field slot
	output logic [47:0] lvl_all, // all level fields, c:b:a
	output logic grant_vld, // a source is selected
	output logic [4:0] grant_id, // selected slot index
	output ils_lvl_t grant_lvl // level of the selected slot
);

	// ------------------------------------------------------------------
	// write masks
	// ------------------------------------------------------------------
	localparam logic SER2X_OK = (PIN_COUNT >= `ILS_SER2X_MIN_PINS);
	localparam logic [15:0] WMASK_A = ~`ILS_RSV_A;
	localparam logic [15:0] WMASK_B = ~`ILS_RSV_B;
	// serial20/21 fields behave as absent on small variants
	localparam logic [15:0] WMASK_C =
		SER2X_OK ? 16'hFFFF : ~`ILS_SER2X_C;

	logic [15:0] lvl_q [0:2];
	ils_dec_t dw;
	ils_dec_t dr;
	logic wr_hit;
	logic [1:0] wr_idx;
	logic [15:0] lane_m;
	logic [15:0] lane_d;
	logic [15:0] wm;
	logic [23:0] slot_ok;

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	function automatic ils_dec_t decode(input logic [15:0] a,
		input logic w);
		ils_dec_t d;
		d.sel = ILS_SEL_NONE;
		d.lane = w ? ILS_LANE_WORD : (a[0] ? ILS_LANE_HI : ILS_LANE_LO);
		case ({a[15:1], 1'b0})
			`ILS_ADDR_A: d.sel = ILS_SEL_A;
			`ILS_ADDR_B: d.sel = ILS_SEL_B;
			`ILS_ADDR_C: d.sel = ILS_SEL_C;
			default: d.sel = ILS_SEL_NONE;
		endcase
		// a word access must be even
		if (w && a[0])
			d.sel = ILS_SEL_NONE;
		return d;
	endfunction

	function automatic logic [1:0] sel_idx(input ils_sel_t s);
		case (s)
			ILS_SEL_B: return 2'h1;
			ILS_SEL_C: return 2'h2;
			default: return 2'h0;
		endcase
	endfunction

	function automatic logic [15:0] wmask_of(input logic [1:0] i);
		case (i)
			2'h1: return WMASK_B;
			2'h2: return WMASK_C;
			default: return WMASK_A;
		endcase
	endfunction

	assign dw = decode(addr, word);
	assign dr = decode(addr, word);

	// ------------------------------------------------------------------
	// write path
	// ------------------------------------------------------------------
	always_comb begin
		wr_hit = wr && (dw.sel != ILS_SEL_NONE);
		wr_idx = sel_idx(dw.sel);
		case (dw.lane)
			ILS_LANE_WORD: begin
				lane_m = 16'hFFFF;
				lane_d = wdata;
			end
			ILS_LANE_HI: begin
				lane_m = 16'hFF00;
				lane_d = {wdata[7:0], 8'h00};
			end
			default: begin
				lane_m = 16'h00FF;
				lane_d = {8'h00, wdata[7:0]};
			end
		endcase
		wm = lane_m & wmask_of(wr_idx);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lvl_q[0] <= `ILS_RESET;
			lvl_q[1] <= `ILS_RESET;
			lvl_q[2] <= `ILS_RESET;
		end else if (wr_hit && level_ctrl_on) begin
			// reserved and absent bits keep their zero
			lvl_q[wr_idx] <= (lvl_q[wr_idx] & ~wm) | (lane_d & wm);
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 16'h0000;
		end else if (rd && dr.sel != ILS_SEL_NONE) begin
			case (dr.lane)
				ILS_LANE_WORD: rdata_q <= lvl_q[sel_idx(dr.sel)];
				ILS_LANE_HI: rdata_q <= {8'h00,
					lvl_q[sel_idx(dr.sel)][15:8]};
				default: rdata_q <= {8'h00, lvl_q[sel_idx(dr.sel)][7:0]};
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// level fields and arbitration
	// ------------------------------------------------------------------
	// slot i is field [2i+1:2i] of a (0-7), b (8-15), c (16-23)
	assign lvl_all = {lvl_q[2], lvl_q[1], lvl_q[0]};

	// slots with no writable field never compete
	always_comb begin
		logic [47:0] m;
		m = {WMASK_C, WMASK_B, WMASK_A};
		for (int i = 0; i < 24; i++)
			slot_ok[i] = |m[2*i +: 2];
	end

	ils_arb #(
		.N(24),
		.IW(5)
	) u_arb (
		.mclk(mclk),
		.nrst(nrst),
		.pend(irq_pend & slot_ok),
		.lvls(lvl_all),
		.lvl_en(level_ctrl_on),
		.grant_vld_q(grant_vld),
		.grant_id_q(grant_id),
		.grant_lvl_q(grant_lvl)
	);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_write_gated_off: assert property (
		wr && !level_ctrl_on |=> $stable(lvl_all))
		else $error("write changed a level while control is off");
	a_reserved_zero: assert property (
		lvl_q[0][3:2] == 2'h0 && lvl_q[1][7:6] == 2'h0)
		else $error("reserved level bits not zero");
	a_absent_zero: assert property (
		SER2X_OK || lvl_q[2][3:0] == 4'h0)
		else $error("absent serial level bits not zero");
	a_word_write_a: assert property (
		wr && level_ctrl_on && word && addr == `ILS_ADDR_A |=>
		lvl_q[0] == ($past(wdata) & WMASK_A))
		else $error("word write to first register wrong");
	a_byte_hi_keeps_lo: assert property (
		wr && level_ctrl_on && !word && addr == `ILS_ADDR_B + 16'h0001
		|=> lvl_q[1][7:0] == $past(lvl_q[1][7:0]) &&
		lvl_q[1][15:8] == $past(wdata[7:0]))
		else $error("high byte write disturbed the low byte");
	a_byte_lo_c: assert property (
		wr && level_ctrl_on && !word && addr == `ILS_ADDR_C |=>
		lvl_q[2][15:8] == $past(lvl_q[2][15:8]) &&
		lvl_q[2][7:0] == ($past(wdata[7:0]) & WMASK_C[7:0]))
		else $error("low byte write to third register wrong");
	a_read_word_b: assert property (
		rd && word && addr == `ILS_ADDR_B |=>
		rdata_q == $past(lvl_q[1]))
		else $error("word read of second register wrong");
	a_read_byte_hi_c: assert property (
		rd && !word && addr == `ILS_ADDR_C + 16'h0001 |=>
		rdata_q == {8'h00, $past(lvl_q[2][15:8])})
		else $error("high byte read of third register wrong");
	a_read_only_after: assert property (
		!$past(rd) |-> rdata_q == 16'h0000)
		else $error("read data present without a read");
	a_other_regs_kept: assert property (
		wr && word && addr == `ILS_ADDR_A |=>
		lvl_all[47:16] == $past(lvl_all[47:16]))
		else $error("write to first register touched another");
	a_bus_fields: assert property (
		wr && level_ctrl_on && word && addr == `ILS_ADDR_A |=>
		lvl_all[`ILS_A_TIMER1 +: 2] == $past(wdata[15:14]) &&
		lvl_all[`ILS_A_TWOWIRE_MASTER1 +: 2] == $past(wdata[7:6]) &&
		lvl_all[`ILS_A_EXPANDED_EXT +: 2] == $past(wdata[1:0]))
		else $error("level bus fields misplaced");
	a_stable_no_write: assert property (
		!wr |=> $stable(lvl_all))
		else $error("levels moved without a write");

	c_word_write: cover property (wr && level_ctrl_on && word &&
		addr == `ILS_ADDR_C);
	c_byte_write_hi: cover property (wr && level_ctrl_on && !word &&
		addr == `ILS_ADDR_A + 16'h0001);
	c_write_blocked: cover property (wr && !level_ctrl_on &&
		dw.sel != ILS_SEL_NONE);
	c_read_after_write: cover property (wr && level_ctrl_on ##1 rd);

endmodule // ils_top
